/* src/bodec_defines.svh */
// Constants for the boolean-op and operand decode block.
// Assumes a core fetch unit supplying opcode and operand bytes.
// Function
// - Carry and bit clear, set, invert
// - Carry becomes carry AND bit
// - Carry becomes carry AND NOT bit
// - Carry becomes carry OR bit
// - Carry becomes carry OR NOT bit
// - Copy bit into carry, one cycle
// - Copy carry into bit, two cycles
// - Indirect address from bank R0/R1
// - Direct byte selects low RAM or special register
// - Immediate byte comes from instruction stream
// - Sixteen-bit immediate from bytes two, three
// - Long target is full 16 bits
// - Page target keeps upper five bits
// - Relative offset signed, from next instruction
// - Low nibble 8..F selects register 0..7
// - Page opcodes low nibble one, odd/even
// - Accumulator self-move left undefined
`ifndef BODEC_DEFINES_SVH
`define BODEC_DEFINES_SVH
`define BODEC_OP_BIT_CLEAR_C 8'hc3
`define BODEC_OP_BIT_CLEAR_B 8'hc2
`define BODEC_OP_BIT_FORCE_HIGH_C 8'hd3
`define BODEC_OP_BIT_FORCE_HIGH_B 8'hd2
`define BODEC_OP_BIT_INVERT_C 8'hb3
`define BODEC_OP_BIT_INVERT_B 8'hb2
`define BODEC_OP_LOGICAL_AND_B 8'h82
`define BODEC_OP_LOGICAL_AND_NB 8'hb0
`define BODEC_OP_LOGICAL_OR_B 8'h72
`define BODEC_OP_LOGICAL_OR_NB 8'ha0
`define BODEC_OP_TRANSFER_CB 8'ha2
`define BODEC_OP_TRANSFER_BC 8'h92
`define BODEC_OP_LONG_JUMP 8'h02
`define BODEC_OP_LONG_CALL 8'h12
`define BODEC_OP_SHORT_BRANCH 8'h80
`define BODEC_PG_LOW_NIBBLE 4'h1
`define BODEC_PG_CALL_BIT 4
`define BODEC_IND_CODE 3'h3
`define BODEC_RST_BIT 1'h0
`define BODEC_RST_BYTE 8'h00
`define BODEC_RST_WREG 5'h00
`define BODEC_RST_WORD 16'h0000
`define BODEC_LOW_RAM_TOP 8'h80
`define BODEC_BIT_RAM_BASE 8'h20
`define BODEC_CYC_ONE 2'h1
`define BODEC_CYC_TWO 2'h2
`endif

/* src/bodec_pkg.sv */
// Types shared by the decode block and its bench.
// Assumes bodec_defines.svh for numeric constants.
package bodec_pkg;
  typedef enum {BODEC_IDLE, BODEC_WAIT} bodec_state_t;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [15:0] next_pc;
    logic valid;
  } bodec_instr_t;
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [2:0] pos;
    logic val;
  } bodec_bitwr_t;
endpackage

/* src/bodec_core.sv */
// Boolean-variable instruction executor and operand decoder.
// Assumes the fetch unit presents whole instructions with next_pc, and
// bit_rd_val is the current value of the bit at b2 (combinational).
`timescale 1ns/1ps
`include "bodec_defines.svh"
module bodec_core
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Instruction in
  input bodec_pkg::bodec_instr_t instr,
  input wire logic [1:0] bank_sel,
  input wire logic [7:0] ptr_r0,
  input wire logic [7:0] ptr_r1,
  input wire logic bit_rd_val,
  // Instruction done and status
  output logic busy,
  output logic done,
  output logic carry,
  output bodec_pkg::bodec_bitwr_t bit_wr,
  // Decoded operands
  output logic [7:0] ram_addr,
  output logic is_special_function_register,
  output logic [4:0] wreg_addr,
  output logic [7:0] imm8,
  output logic [15:0] imm16,
  output logic [15:0] branch_target,
  output logic is_call
);
  // ***************************************************************
  // Helper functions
  // ***************************************************************
  // Byte holding a bit: RAM 20h..2Fh below 80h, special regs above
  function automatic logic [7:0] bit_byte(input logic [7:0] a);
    bit_byte = a[7] ? {a[7:3], 3'h0} :
      (`BODEC_BIT_RAM_BASE + {4'h0, a[6:3]});
  endfunction

  // Sign extension of a relative offset byte
  function automatic logic [15:0] sext8(input logic [7:0] b);
    sext8 = {{8{b[7]}}, b};
  endfunction

  // ***************************************************************
  // Instruction fields
  // ***************************************************************
  wire logic [7:0] op = instr.op;
  wire logic [7:0] b2 = instr.b2;
  wire logic [7:0] b3 = instr.b3;
  wire logic [15:0] next_pc = instr.next_pc;

  // ***************************************************************
  // Opcode match
  // ***************************************************************
  wire logic op_clear_c = op == `BODEC_OP_BIT_CLEAR_C;
  wire logic op_clear_b = op == `BODEC_OP_BIT_CLEAR_B;
  wire logic op_set_c = op == `BODEC_OP_BIT_FORCE_HIGH_C;
  wire logic op_set_b = op == `BODEC_OP_BIT_FORCE_HIGH_B;
  wire logic op_inv_c = op == `BODEC_OP_BIT_INVERT_C;
  wire logic op_inv_b = op == `BODEC_OP_BIT_INVERT_B;
  wire logic op_and_b = op == `BODEC_OP_LOGICAL_AND_B;
  wire logic op_and_nb = op == `BODEC_OP_LOGICAL_AND_NB;
  wire logic op_or_b = op == `BODEC_OP_LOGICAL_OR_B;
  wire logic op_or_nb = op == `BODEC_OP_LOGICAL_OR_NB;
  wire logic op_bit_to_c = op == `BODEC_OP_TRANSFER_CB;
  wire logic op_c_to_bit = op == `BODEC_OP_TRANSFER_BC;
  wire logic op_long_jump = op == `BODEC_OP_LONG_JUMP;
  wire logic op_long_call = op == `BODEC_OP_LONG_CALL;
  wire logic op_short_branch = op == `BODEC_OP_SHORT_BRANCH;

  // ***************************************************************
  // Addressing forms
  // ***************************************************************
  wire logic is_pg = op[3:0] == `BODEC_PG_LOW_NIBBLE;
  wire logic pg_is_call = op[`BODEC_PG_CALL_BIT];
  wire logic is_work_reg = op[3];
  wire logic is_ind = op[3:1] == `BODEC_IND_CODE;
  wire logic is_long = op_long_jump || op_long_call;
  wire logic is_branch = is_pg || is_long || op_short_branch;
  wire logic bool_op = op_clear_b || op_set_b || op_inv_b ||
    op_and_b || op_and_nb || op_or_b || op_or_nb ||
    op_bit_to_c || op_c_to_bit;

  // ***************************************************************
  // Operand addresses
  // ***************************************************************
  wire logic [7:0] ind_ptr = op[0] ? ptr_r1 : ptr_r0;
  wire logic [7:0] bit_home = bit_byte(b2);
  wire logic [7:0] dir_addr = bool_op ? bit_home : b2;
  // Accumulator self-move is not trapped; its outcome is don't-care
  wire logic [7:0] ram_nxt = is_ind ? ind_ptr : dir_addr;
  wire logic spec_nxt = !is_ind && dir_addr >= `BODEC_LOW_RAM_TOP;
  wire logic [4:0] wreg_nxt = {bank_sel, op[2:0]};

  // ***************************************************************
  // Immediates and targets
  // ***************************************************************
  wire logic [7:0] imm8_nxt = b2;
  wire logic [15:0] imm16_nxt = {b2, b3};
  wire logic [15:0] rel_tgt = next_pc + sext8(b2);
  // Upper five bits follow the next instruction, keeping the page
  wire logic [15:0] pg_tgt = {next_pc[15:11], op[7:5], b2};
  wire logic [15:0] long_tgt = {b2, b3};
  wire logic [15:0] tgt_nxt = is_pg ? pg_tgt :
    (is_long ? long_tgt : rel_tgt);
  wire logic call_nxt = (is_pg && pg_is_call) || op_long_call;

  // ***************************************************************
  // Carry and bit results
  // ***************************************************************
  logic carry_nxt;
  logic wr_nxt;
  logic val_nxt;
  logic [1:0] cyc_nxt;
  always_comb
  begin
    carry_nxt = carry;
    wr_nxt = 1'b0;
    val_nxt = 1'b0;
    cyc_nxt = `BODEC_CYC_ONE;
    unique case (op)
      `BODEC_OP_BIT_CLEAR_C: carry_nxt = 1'b0;
      `BODEC_OP_BIT_FORCE_HIGH_C: carry_nxt = 1'b1;
      `BODEC_OP_BIT_INVERT_C: carry_nxt = !carry;
      `BODEC_OP_BIT_CLEAR_B:
      begin
        wr_nxt = 1'b1;
        val_nxt = 1'b0;
      end
      `BODEC_OP_BIT_FORCE_HIGH_B:
      begin
        wr_nxt = 1'b1;
        val_nxt = 1'b1;
      end
      `BODEC_OP_BIT_INVERT_B:
      begin
        wr_nxt = 1'b1;
        val_nxt = !bit_rd_val;
      end
      `BODEC_OP_LOGICAL_AND_B:
      begin
        carry_nxt = carry & bit_rd_val;
        cyc_nxt = `BODEC_CYC_TWO;
      end
      `BODEC_OP_LOGICAL_AND_NB:
      begin
        carry_nxt = carry & !bit_rd_val;
        cyc_nxt = `BODEC_CYC_TWO;
      end
      `BODEC_OP_LOGICAL_OR_B:
      begin
        carry_nxt = carry | bit_rd_val;
        cyc_nxt = `BODEC_CYC_TWO;
      end
      `BODEC_OP_LOGICAL_OR_NB:
      begin
        carry_nxt = carry | !bit_rd_val;
        cyc_nxt = `BODEC_CYC_TWO;
      end
      `BODEC_OP_TRANSFER_CB: carry_nxt = bit_rd_val;
      `BODEC_OP_TRANSFER_BC:
      begin
        wr_nxt = 1'b1;
        val_nxt = carry;
        cyc_nxt = `BODEC_CYC_TWO;
      end
      default:
      begin
        if (is_branch)
          cyc_nxt = `BODEC_CYC_TWO;
      end
    endcase
  end

  // ***************************************************************
  // Sequencing
  // ***************************************************************
  bodec_pkg::bodec_state_t st_r;
  bodec_pkg::bodec_state_t st_nxt;
  logic wr_pending_r;
  wire logic take = instr.valid && st_r == bodec_pkg::BODEC_IDLE;
  wire logic two = cyc_nxt == `BODEC_CYC_TWO;
  wire logic in_wait = st_r == bodec_pkg::BODEC_WAIT;
  wire logic busy_nxt = take && two;
  wire logic done_nxt = (take && !two) || in_wait;
  // Bit write of a two-cycle op is held back to its second cycle
  wire logic we_nxt = (take && wr_nxt && !two) ||
    (in_wait && wr_pending_r);
  wire logic pending_nxt = take && wr_nxt && two;

  always_comb
  begin
    st_nxt = bodec_pkg::BODEC_IDLE;
    unique case (st_r)
      bodec_pkg::BODEC_IDLE:
        if (take && two)
          st_nxt = bodec_pkg::BODEC_WAIT;
      bodec_pkg::BODEC_WAIT:
        st_nxt = bodec_pkg::BODEC_IDLE;
    endcase
  end

  bodec_pkg::bodec_bitwr_t bit_wr_nxt;
  always_comb
  begin
    bit_wr_nxt = bit_wr;
    bit_wr_nxt.we = we_nxt;
    if (take)
    begin
      bit_wr_nxt.addr = bit_home;
      bit_wr_nxt.pos = b2[2:0];
      bit_wr_nxt.val = val_nxt;
    end
  end

  // ***************************************************************
  // State registers
  // ***************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_r <= bodec_pkg::BODEC_IDLE;
    else
      st_r <= st_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wr_pending_r <= `BODEC_RST_BIT;
    else
      wr_pending_r <= pending_nxt;
  end

  // ***************************************************************
  // Output registers
  // ***************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      busy <= `BODEC_RST_BIT;
    else
      busy <= busy_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      done <= `BODEC_RST_BIT;
    else
      done <= done_nxt;
  end

  // Two-cycle carry ops commit at take; carry stands until next take
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      carry <= `BODEC_RST_BIT;
    else if (take)
      carry <= carry_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      bit_wr <= '0;
    else
      bit_wr <= bit_wr_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ram_addr <= `BODEC_RST_BYTE;
    else if (take)
      ram_addr <= ram_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      is_special_function_register <= `BODEC_RST_BIT;
    else if (take)
      is_special_function_register <= spec_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wreg_addr <= `BODEC_RST_WREG;
    else if (take && is_work_reg)
      wreg_addr <= wreg_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      imm8 <= `BODEC_RST_BYTE;
    else if (take)
      imm8 <= imm8_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      imm16 <= `BODEC_RST_WORD;
    else if (take)
      imm16 <= imm16_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      branch_target <= `BODEC_RST_WORD;
    else if (take)
      branch_target <= tgt_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      is_call <= `BODEC_RST_BIT;
    else if (take)
      is_call <= call_nxt;
  end
endmodule // bodec_core

/* dv/bodec_asserts.sv */
// Checker for bodec_core, bound to every instance.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
module bodec_asserts
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Inputs watched
  input bodec_pkg::bodec_instr_t instr,
  input wire logic [1:0] bank_sel,
  input wire logic bit_rd_val,
  // Outputs watched
  input wire logic busy,
  input wire logic done,
  input wire logic carry,
  input bodec_pkg::bodec_bitwr_t bit_wr,
  input wire logic [4:0] wreg_addr,
  input wire logic [15:0] imm16,
  input wire logic [15:0] branch_target
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire tk = instr.valid & ~busy;
  wire [7:0] op = instr.op;
  wire [4:0] wr = {bank_sel, instr.op[2:0]};
  wire [15:0] bb = {instr.b2, instr.b3};
  wire [15:0] pg = {instr.next_pc[15:11], instr.op[7:5], instr.b2};
  sequence s_two; busy ##1 done && bit_wr.we; endsequence
  property p_clr; tk && op == 8'hc3 |=> done && !carry; endproperty
  a_clr: assert property (p_clr) else $error("carry clear");
  property p_cpl; tk && op == 8'hb3 |=> carry != $past(carry); endproperty
  a_cpl: assert property (p_cpl) else $error("carry invert");
  property p_anl; tk && op == 8'h82 |=>
    busy && carry == ($past(carry) & $past(bit_rd_val)) ##1 done; endproperty
  a_anl: assert property (p_anl) else $error("carry and bit");
  property p_mcb; tk && op == 8'ha2 |=>
    done && !busy && carry == $past(bit_rd_val); endproperty
  a_mcb: assert property (p_mcb) else $error("bit to carry");
  property p_mbc; tk && op == 8'h92 |=>
    s_two ##0 bit_wr.val == $past(carry, 2); endproperty
  a_mbc: assert property (p_mbc) else $error("carry to bit");
  property p_wreg; tk && op[3] |=> wreg_addr == $past(wr); endproperty
  a_wreg: assert property (p_wreg) else $error("work reg");
  property p_imm; tk |=> imm16 == $past(bb); endproperty
  a_imm: assert property (p_imm) else $error("imm16");
  property p_page; tk && op[4:0] == 5'h01 |=>
    branch_target == $past(pg); endproperty
  a_page: assert property (p_page) else $error("page target");
endmodule // bodec_asserts

bind bodec_core bodec_asserts u_chk (.clk(clk), .rst_n(rst_n),
  .instr(instr), .bank_sel(bank_sel), .bit_rd_val(bit_rd_val),
  .busy(busy), .done(done), .carry(carry), .bit_wr(bit_wr),
  .wreg_addr(wreg_addr), .imm16(imm16), .branch_target(branch_target));

/* dv/bodec_pmem.sv */
// Program memory model presenting whole instructions.
// Assumes the core takes instr at an edge where busy is low.
`timescale 1ns/1ps
module bodec_pmem
(
  // Clock and handshake
  input wire logic clk,
  input wire logic busy,
  // Instruction and addressed bit
  output bodec_pkg::bodec_instr_t instr,
  output logic bit_val
);
  initial instr = '0;
  initial bit_val = 1'b0;
  task automatic fetch(input logic [7:0] op, b2, b3,
    input logic [15:0] pc, input logic bv);
    @(posedge clk);
    instr <= {op, b2, b3, pc, 1'b1};
    bit_val <= bv;
    @(negedge clk);
    while (busy)
      @(negedge clk);
    @(posedge clk);
    // Released lines show garbage, not the old value
    instr <= ~{op, b2, b3, pc, 1'b1};
    bit_val <= ~bv;
  endtask
endmodule // bodec_pmem

/* dv/boolean_op_and_operand_decode_tb.sv */
// Self-checking bench for bodec_core.
// Assumes bodec_pmem and the bound checker are compiled alongside.
`timescale 1ns/1ps
module boolean_op_and_operand_decode_tb;
  logic clk = 0, rst_n = 0, bv, busy, done, carry, is_call, c = 0;
  logic is_special_function_register;
  logic [1:0] bank_sel = 2'h0;
  logic [7:0] ptr_r0 = 8'h00, ptr_r1 = 8'h00, ram_addr, imm8;
  logic [4:0] wreg_addr;
  logic [15:0] imm16, tgt;
  bodec_pkg::bodec_instr_t instr;
  bodec_pkg::bodec_bitwr_t bit_wr;
  int error_cnt = 0, checked = 0;
  always #5 clk = ~clk;
  bodec_pmem pm (.clk(clk), .busy(busy), .instr(instr), .bit_val(bv));
  bodec_core dut (.clk(clk), .rst_n(rst_n), .instr(instr),
    .bank_sel(bank_sel), .ptr_r0(ptr_r0), .ptr_r1(ptr_r1),
    .bit_rd_val(bv), .busy(busy), .done(done), .carry(carry),
    .bit_wr(bit_wr), .ram_addr(ram_addr),
    .is_special_function_register(is_special_function_register),
    .wreg_addr(wreg_addr), .imm8(imm8), .imm16(imm16),
    .branch_target(tgt), .is_call(is_call));
  task automatic chk(input logic [15:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [7:0] op, b2, b3, input logic b,
    input int cyc);
    pm.fetch(op, b2, b3, 16'h7ffe, b);
    @(negedge clk);
    chk(busy, cyc == 2);
    if (cyc == 2)
      @(negedge clk);
    chk(done, 1'b1);
  endtask
  task automatic t_carry;
    logic [7:0] ops [9] = '{8'hc3, 8'hd3, 8'hb3, 8'hb3, 8'h82, 8'hb0,
      8'h72, 8'ha0, 8'ha2};
    logic [7:0] o;
    logic b;
    for (int k = 0; k < 27; k++)
    begin
      o = ops[k % 9];
      b = k[1] ^ k[3];
      case (o)
        8'hc3: c = 1'b0;
        8'hd3: c = 1'b1;
        8'hb3: c = ~c;
        8'h82: c = c & b;
        8'hb0: c = c & ~b;
        8'h72: c = c | b;
        8'ha0: c = c | ~b;
        default: c = b;
      endcase
      run(o, 8'h21, 8'h00, b, (o[1:0] == 2'h3 || o == 8'ha2) ? 1 : 2);
      chk(carry, c);
    end
  endtask
  task automatic t_bitwr;
    logic [7:0] ops [4] = '{8'hc2, 8'hd2, 8'hb2, 8'h92};
    logic [7:0] o, a;
    logic v;
    for (int k = 0; k < 8; k++)
    begin
      o = ops[k % 4];
      a = k[2] ? 8'h93 : 8'h0a;
      v = o == 8'hc2 ? 1'b0 : o == 8'hd2 ? 1'b1 : o == 8'hb2 ? ~k[0] : c;
      run(o, a, 8'h00, k[0], o == 8'h92 ? 2 : 1);
      chk(bit_wr, {1'b1, k[2] ? 8'h90 : 8'h21, a[2:0], v});
      @(negedge clk);
      chk(bit_wr.we, 1'b0);
      chk(done, 1'b0);
    end
  endtask
  task automatic t_operand;
    logic [7:0] jo [6] = '{8'h02, 8'h12, 8'he1, 8'h31, 8'h80, 8'h80};
    logic [7:0] jb [6] = '{8'h12, 8'h12, 8'h56, 8'h56, 8'h80, 8'h7f};
    logic [15:0] jt [6] = '{16'h1234, 16'h1234, 16'h7f56, 16'h7956,
      16'h7f7e, 16'h807d};
    @(posedge clk);
    bank_sel <= 2'h2;
    ptr_r0 <= 8'h5a;
    ptr_r1 <= 8'ha5;
    run(8'he6, 8'h00, 8'h00, 1'b0, 1);
    chk(ram_addr, 8'h5a);
    run(8'he7, 8'h00, 8'h00, 1'b0, 1);
    chk(ram_addr, 8'ha5);
    run(8'he5, 8'h90, 8'h00, 1'b0, 1);
    chk(ram_addr, 8'h90);
    chk(is_special_function_register, 1'b1);
    run(8'he5, 8'h45, 8'h00, 1'b0, 1);
    chk(ram_addr, 8'h45);
    chk(is_special_function_register, 1'b0);
    run(8'hef, 8'h00, 8'h00, 1'b0, 1);
    chk(wreg_addr, 5'h17);
    run(8'h74, 8'hc5, 8'h00, 1'b0, 1);
    chk(imm8, 8'hc5);
    for (int k = 0; k < 6; k++)
    begin
      run(jo[k], jb[k], 8'h34, 1'b0, 2);
      chk(tgt, jt[k]);
      chk(imm16, {jb[k], 8'h34});
      chk(is_call, k == 1 || k == 3);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_carry();
    t_bitwr();
    t_operand();
    stop_test();
  end
  initial
  begin
    #20000;
    error_cnt++;
    stop_test();
  end
endmodule // boolean_op_and_operand_decode_tb
